// ---- logic/pst_top.sv ----
// Panel scan timing generator with tear output and AHB-Lite registers.
// Assumes one 40 MHz clock, a single bus master and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Command 35h enables tear, 34h disables
// - Disabled tear low; param bit0 picks mode
// - Command 44h sets tear line; pulse there
// - Progressive scan forward or reverse by direction
// - Interlace: odd then even, or reverse
// - Polarity inverts every field plus one lines
// - Frame period from clocks, divider, lines
// - Eight-bit clocks per line sets period
// - Display lines plus porches form frame
module pst_top
  import pst_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tear_out,
  output logic [8:0] gate_line,
  output logic gate_active,
  output logic drive_polarity,
  output logic frame_start
);

  // All state of the block except the divider count
  typedef struct packed {
    pst_bus_e bus;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic tear_output_on;
    logic tear_mode_select;
    logic [8:0] tear_line_select;
    logic interlace_scan_select;
    logic gate_scan_direction;
    logic [1:0] div_sel;
    logic [7:0] clocks_per_line;
    logic [7:0] front_porch_lines;
    logic [7:0] back_porch_lines;
    logic [8:0] display_line_count;
    logic [5:0] inversion_line_count;
    logic [7:0] clk_cnt;
    logic [9:0] line_cnt;
    logic [5:0] inv_cnt;
    logic line_pol;
    logic frame_pol;
    logic te;
    logic [8:0] gate;
    logic gate_on;
    logic fstart;
  } pst_state_s;

  pst_state_s s;
  pst_state_s next_s;
  logic tick; // Divided operation clock enable
  logic [9:0] total_lines; // Display plus porch lines
  logic [7:0] cpl_last; // Last clock index in a line

  // Gate line for display index, per scan order
  function automatic logic [8:0] gate_map(input logic [9:0] idx, input logic [8:0] nl,
                                          input logic sm, input logic gs);
    logic [8:0] i;
    logic [8:0] half;
    i = idx[8:0];
    half = {1'b0, nl[8:1]};
    if (!sm) begin
      gate_map = gs ? (nl - i) : (i + 9'h001);
    end else if (!gs) begin
      gate_map = (i < half) ? {i[7:0], 1'b1} : {i[7:0] - half[7:0], 1'b0} + 9'h002;
    end else begin
      gate_map = (i < half) ? (nl - {i[7:0], 1'b0}) : (nl - 9'h001 - {i[7:0] - half[7:0], 1'b0});
    end
  endfunction

  // Register read multiplexer
  function automatic logic [31:0] read_mux(input logic [7:0] addr, input pst_state_s st);
    read_mux = 32'h0000_0000;
    case (addr)
      PST_CTRL_OFS: begin
        read_mux[PST_CTRL_TEAR_ON_BIT] = st.tear_output_on;
        read_mux[PST_CTRL_TEAR_MODE_BIT] = st.tear_mode_select;
        read_mux[PST_CTRL_INTERLACE_BIT] = st.interlace_scan_select;
        read_mux[PST_CTRL_DIRECTION_BIT] = st.gate_scan_direction;
        read_mux[PST_CTRL_DIV_LSB +: 2] = st.div_sel;
      end
      PST_TIMING_OFS: begin
        read_mux[23:0] = {st.back_porch_lines, st.front_porch_lines, st.clocks_per_line};
      end
      PST_LINES_OFS: begin
        read_mux[8:0] = st.display_line_count;
        read_mux[21:16] = st.inversion_line_count;
      end
      PST_CMD_OFS: begin
        read_mux[24:16] = st.tear_line_select;
      end
      PST_STATUS_OFS: begin
        read_mux[9:0] = st.line_cnt;
        read_mux[24:16] = st.gate;
        read_mux[25] = st.frame_pol;
        read_mux[26] = st.line_pol;
        read_mux[27] = st.te;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  endfunction

  // Operation clock divider
  pst_clk_div u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .div_sel(s.div_sel),
    .tick(tick)
  );

  // Frame length and line length
  assign total_lines = 10'(s.display_line_count) + 10'(s.front_porch_lines)
                     + 10'(s.back_porch_lines);
  assign cpl_last = (s.clocks_per_line == 8'h00) ? 8'h00 : s.clocks_per_line - 8'h01;

  // Bus answers: stalls only while the block is frozen
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign tear_out = s.te;
  assign gate_line = s.gate;
  assign gate_active = s.gate_on;
  assign drive_polarity = s.frame_pol ^ s.line_pol;
  assign frame_start = s.fstart;

  // Next state of bus, registers and scan
  always_comb begin
    next_s = s;
    next_s.fstart = 1'b0;
    // Data phase: perform register write
    if (s.bus == PST_BUS_DATA && s.ap_write) begin
      case (s.ap_addr)
        PST_CTRL_OFS: begin
          next_s.interlace_scan_select = hwdata[PST_CTRL_INTERLACE_BIT];
          next_s.gate_scan_direction = hwdata[PST_CTRL_DIRECTION_BIT];
          next_s.div_sel = hwdata[PST_CTRL_DIV_LSB +: 2];
        end
        PST_TIMING_OFS: begin
          next_s.clocks_per_line = hwdata[7:0];
          next_s.front_porch_lines = hwdata[15:8];
          next_s.back_porch_lines = hwdata[23:16];
        end
        PST_LINES_OFS: begin
          next_s.display_line_count = hwdata[8:0];
          next_s.inversion_line_count = hwdata[21:16];
        end
        PST_CMD_OFS: begin
          // Command opcode in low byte, parameters above
          case (hwdata[7:0])
            PST_CMD_TEAR_ON: begin
              next_s.tear_output_on = 1'b1;
              next_s.tear_mode_select = hwdata[8];
            end
            PST_CMD_TEAR_OFF: begin
              next_s.tear_output_on = 1'b0;
            end
            PST_CMD_TEAR_LINE: begin
              next_s.tear_line_select = hwdata[24:16];
            end
            default: begin
              next_s.tear_output_on = s.tear_output_on;
            end
          endcase
        end
        default: begin
          next_s.ap_write = s.ap_write;
        end
      endcase
    end
    // Address phase capture
    if (hsel && hready && htrans[1]) begin
      next_s.bus = PST_BUS_DATA;
      next_s.ap_write = hwrite;
      next_s.ap_addr = haddr[7:0];
      if (!hwrite) begin
        next_s.rdata = read_mux(haddr[7:0], s);
      end
    end else begin
      next_s.bus = PST_BUS_IDLE;
    end
    // Scan timing on each operation clock
    if (tick) begin
      if (s.clk_cnt >= cpl_last) begin
        next_s.clk_cnt = 8'h00;
        if (s.line_cnt >= total_lines - 10'h001) begin
          next_s.line_cnt = 10'h000;
          next_s.frame_pol = ~s.frame_pol;
          next_s.inv_cnt = 6'h00;
          next_s.line_pol = 1'b0;
          next_s.fstart = 1'b1;
        end else begin
          next_s.line_cnt = s.line_cnt + 10'h001;
          if (s.inv_cnt >= s.inversion_line_count) begin
            next_s.inv_cnt = 6'h00;
            next_s.line_pol = ~s.line_pol;
          end else begin
            next_s.inv_cnt = s.inv_cnt + 6'h01;
          end
        end
      end else begin
        next_s.clk_cnt = s.clk_cnt + 8'h01;
      end
    end
    // Gate line in display region only
    next_s.gate_on = (s.line_cnt < 10'(s.display_line_count));
    next_s.gate = next_s.gate_on ? gate_map(s.line_cnt, s.display_line_count,
                  s.interlace_scan_select, s.gate_scan_direction) : 9'h000;
    // Tear output
    if (!s.tear_output_on) begin
      next_s.te = 1'b0;
    end else if (!s.tear_mode_select) begin
      next_s.te = (s.line_cnt == 10'(s.tear_line_select));
    end else begin
      next_s.te = (s.line_cnt == 10'(s.tear_line_select))
               || ({1'b0, s.clk_cnt} + {1'b0, PST_HBLANK_CLKS} > {1'b0, cpl_last});
    end
  end

  // State register, frozen while clk_en is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.clocks_per_line <= PST_CPL_RST;
      s.front_porch_lines <= PST_FP_RST;
      s.back_porch_lines <= PST_BP_RST;
      s.display_line_count <= PST_NL_RST;
      s.inversion_line_count <= PST_INV_RST;
      s.div_sel <= PST_DIV_RST;
      s.tear_line_select <= PST_TEL_RST;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// ---- logic/pst_pkg.sv ----
// Constants, register map and state type for the panel scan timing block.
// Assumes a single 40 MHz clock and an AHB-Lite register port with 32-bit data.
package pst_pkg;

  // Register byte offsets
  localparam logic [7:0] PST_CTRL_OFS = 8'h00;
  localparam logic [7:0] PST_TIMING_OFS = 8'h04;
  localparam logic [7:0] PST_LINES_OFS = 8'h08;
  localparam logic [7:0] PST_CMD_OFS = 8'h0C;
  localparam logic [7:0] PST_STATUS_OFS = 8'h10;

  // Control field positions
  localparam int PST_CTRL_TEAR_ON_BIT = 0;
  localparam int PST_CTRL_TEAR_MODE_BIT = 1;
  localparam int PST_CTRL_INTERLACE_BIT = 2;
  localparam int PST_CTRL_DIRECTION_BIT = 3;
  localparam int PST_CTRL_DIV_LSB = 4;

  // Host command opcodes
  localparam logic [7:0] PST_CMD_TEAR_OFF = 8'h34;
  localparam logic [7:0] PST_CMD_TEAR_ON = 8'h35;
  localparam logic [7:0] PST_CMD_TEAR_LINE = 8'h44;

  // Values after reset
  localparam logic [7:0] PST_CPL_RST = 8'h78;
  localparam logic [7:0] PST_FP_RST = 8'h08;
  localparam logic [7:0] PST_BP_RST = 8'h08;
  localparam logic [8:0] PST_NL_RST = 9'h140;
  localparam logic [5:0] PST_INV_RST = 6'h00;
  localparam logic [1:0] PST_DIV_RST = 2'h0;
  localparam logic [8:0] PST_TEL_RST = 9'h000;

  // Operation clocks at the end of each line flagged as horizontal blanking
  localparam logic [7:0] PST_HBLANK_CLKS = 8'h08;

  // Bus data-phase tracking
  typedef enum logic [0:0] {
    PST_BUS_IDLE = 1'b0,
    PST_BUS_DATA = 1'b1
  } pst_bus_e;

endpackage

// ---- logic/pst_clk_div.sv ----
// Operation clock divider: one tick every 1, 2, 4 or 8 clocks.
// Assumes clk_en freezes its state like the rest of the block.
`timescale 1ns/1ps
`default_nettype none
module pst_clk_div
  import pst_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [1:0] div_sel,
  output logic tick
);

  // Free running prescale count
  logic [2:0] cnt;
  logic [2:0] mask;

  // Mask of low count bits for the chosen ratio
  always_comb begin
    case (div_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // Tick when masked count wraps
  assign tick = clk_en && ((cnt & mask) == 3'h0);

  // Prescale counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
    end else if (clk_en) begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule
`default_nettype wire

// ---- verif/pst_top_asserts.sv ----
// Port checker for the scan timing block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pst_top_asserts
  import pst_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tear_out,
  input wire logic [8:0] gate_line,
  input wire logic gate_active,
  input wire logic drive_polarity,
  input wire logic frame_start
);
  logic cmd_phase; // Command write in data phase
  // Track data phases of command writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_phase <= 1'b0;
    end else if (hready) begin
      cmd_phase <= hsel && htrans[1] && hwrite && (haddr[7:0] == PST_CMD_OFS);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("Response not OKAY");
  AST_READY_ECHO: assert property (hreadyout == clk_en) else $error("Ready differs");
  AST_PORCH_IDLE: assert property (!gate_active |-> gate_line == 9'h000)
    else $error("Gate line in porch");
  AST_GATE_RANGE: assert property (gate_active |-> gate_line != 9'h000 && gate_line <= 9'h140)
    else $error("Gate line out of range");
  AST_FRAME_PULSE: assert property (frame_start |=> !frame_start [*8])
    else $error("Frame pulse too long");
  AST_FRAME_FIRST: assert property (frame_start |-> ##[0:1] gate_active)
    else $error("Frame not led by display line");
  AST_TEAR_OFF: assert property (cmd_phase && hready && hwdata[7:0] == PST_CMD_TEAR_OFF
    |-> ##2 !tear_out [*4]) else $error("Tear high after off");
  // Polarity flips at a line end, one cycle before the gate line moves on
  AST_POL_STEADY: assert property ($changed(drive_polarity) && gate_active
    |=> $changed(gate_line)) else $error("Polarity moved mid line");
endmodule
`default_nettype wire

// ---- verif/pst_host_model.sv ----
// Host processor model: AHB-Lite master, tear-synchronised start.
// Assumes the slave on the same clock drives hready.
`timescale 1ns/1ps
`default_nettype none
module pst_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic tear_out,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Single word transfer, read data taken at data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released lines change rather than hold
    haddr <= ~haddr;
    hwdata <= ~d;
  endtask
  // Waits for a tear rise, sampled at falling edges; gives up after 4000 cycles
  task automatic wait_tear(output logic seen);
    int n = 0;
    while (tear_out === 1'b1 && n < 4000) begin
      @(negedge hclk);
      n++;
    end
    while (tear_out !== 1'b1 && n < 4000) begin
      @(negedge hclk);
      n++;
    end
    seen = tear_out;
  endtask
endmodule
`default_nettype wire

// ---- verif/panel_scan_timing_tear_output_bench.sv ----
// Bench for the scan timing block: scan order, timing, tear, polarity.
// Assumes the host model as bus master and hready fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module panel_scan_timing_tear_output_bench
  import pst_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, seen;
  logic clk_en; // Block clock enable, driven by the bench
  logic [31:0] snap; // Outputs captured at the start of a freeze
  logic tear_out, gate_active, drive_polarity, frame_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] gate_line;
  int fails, checks, cyc;
  // Row: control, tear opcode, mode, tear line, gate order
  typedef struct packed {
    logic [7:0] ctrl; logic [7:0] op; logic mode; logic [3:0] tl; logic [31:0] seq;
  } pst_row_s;
  pst_row_s rows [4] = '{'{8'h00, 8'h35, 1'b0, 4'h3, 32'h12345678},
                         '{8'h18, 8'h35, 1'b1, 4'h0, 32'h87654321},
                         '{8'h24, 8'h34, 1'b1, 4'h3, 32'h13572468},
                         '{8'h3C, 8'h35, 1'b0, 4'hB, 32'h86427531}};
  pst_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tear_out(tear_out),
    .gate_line(gate_line), .gate_active(gate_active), .drive_polarity(drive_polarity),
    .frame_start(frame_start));
  pst_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .tear_out(tear_out),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  // Oscillator far above frame rate x lines x 64
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Configure one row, then follow a whole frame line by line
  task automatic run_row(input pst_row_s r);
    int lp, c, li, dv;
    logic p0, on;
    logic [3:0] nib;
    dv = int'(r.ctrl[5:4]);
    lp = 16 << dv;
    on = (r.op == PST_CMD_TEAR_ON);
    wr(PST_CTRL_OFS, {24'h0, r.ctrl});
    wr(PST_CMD_OFS, {23'h0, r.mode, r.op});
    wr(PST_CMD_OFS, {12'h0, r.tl, 8'h0, PST_CMD_TEAR_LINE});
    c = 0;
    while (frame_start !== 1'b1 && c < 4000) begin
      @(negedge hclk);
      c++;
    end
    for (c = 1; c <= 12 * lp; c++) begin
      @(negedge hclk);
      li = c / lp;
      nib = (li < 8) ? r.seq[31 - 4 * li -: 4] : 4'h0;
      chk({31'h0, frame_start}, {31'h0, c == 12 * lp});
      if (c % lp == (3 << dv)) begin
        if (li == 0) p0 = drive_polarity;
        chk({23'h0, gate_line}, {28'h0, nib});
        chk({31'h0, gate_active}, {31'h0, li < 8});
        chk({31'h0, drive_polarity ^ p0}, {31'h0, li[1]});
        chk({31'h0, tear_out}, {31'h0, on && li == r.tl});
      end
      // Late in the line mode 1 adds horizontal blanking
      if (c % lp == (13 << dv)) begin
        chk({31'h0, tear_out}, {31'h0, on && (li == r.tl || r.mode)});
      end
    end
  endtask
  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    fails = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk({28'h0, tear_out, gate_active, drive_polarity, frame_start}, 32'h0);
    @(posedge hclk) hresetn <= 1'b1;
    rdc(PST_TIMING_OFS, 32'hFFFFFFFF, 32'h00080878);
    rdc(PST_LINES_OFS, 32'h003F01FF, 32'h00000140);
    wr(PST_TIMING_OFS, 32'h00020210);
    wr(PST_LINES_OFS, 32'h00010008);
    for (int i = 0; i < 4; i++) run_row(rows[i]);
    // Control readback, then tear bits stay read-only on a control write
    rdc(PST_CTRL_OFS, 32'h3F, 32'h3D);
    wr(PST_CTRL_OFS, 32'h2);
    rdc(PST_CTRL_OFS, 32'h3F, 32'h01);
    // Unknown opcode and unmapped write leave the tear setup alone
    wr(PST_CMD_OFS, 32'h00000199);
    wr(8'h20, 32'hFFFFFFFF);
    rdc(PST_CTRL_OFS, 32'h3F, 32'h01);
    rdc(PST_CMD_OFS, 32'h01FF0000, 32'h000B0000);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    host.wait_tear(seen);
    chk({31'h0, seen}, 32'h1);
    // Freeze on the tear line: outputs hold and the bus stalls
    @(posedge hclk) clk_en <= 1'b0;
    @(negedge hclk);
    snap = {20'h0, gate_line, gate_active, drive_polarity, tear_out};
    chk({31'h0, hreadyout}, 32'h0);
    repeat (20) @(posedge hclk);
    @(negedge hclk);
    chk({20'h0, gate_line, gate_active, drive_polarity, tear_out}, snap);
    chk({31'h0, tear_out}, 32'h1);
    @(posedge hclk) clk_en <= 1'b1;
    // Reset in mid-run: outputs clear, registers back to defaults
    @(posedge hclk) hresetn <= 1'b0;
    @(negedge hclk);
    chk({19'h0, gate_line, tear_out, gate_active, drive_polarity, frame_start}, 32'h0);
    chk(hrdata, 32'h0);
    @(posedge hclk) hresetn <= 1'b1;
    rdc(PST_STATUS_OFS, 32'h0FFF03FF, 32'h00010000);
    rdc(PST_TIMING_OFS, 32'hFFFFFFFF, 32'h00080878);
    rdc(PST_CTRL_OFS, 32'h3F, 32'h00);
    tally_and_finish();
  end
endmodule
bind pst_top pst_top_asserts chk_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tear_out(tear_out),
  .gate_line(gate_line), .gate_active(gate_active), .drive_polarity(drive_polarity),
  .frame_start(frame_start));
`default_nettype wire
